/* File: logic/adcsq_pkg.sv */
// Constants shared by the converter sequencer control block
package adcsq_pkg;
  // Result and channel widths
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned SLOTS = 8;
  localparam int unsigned DELAY_W = 8;
  localparam int unsigned PLL_SET_W = 3;
  localparam int unsigned PEND_MAX = 2;
  // Converter clock is two thirds of the switcher PLL output
  localparam int unsigned CORE_NUM = 2;
  localparam int unsigned CORE_DEN = 3;
  // Switcher PLL output for setting 0 and per setting step, plain defaults
  localparam int unsigned PLL_BASE_HZ = 3_000_000;
  localparam int unsigned PLL_STEP_HZ = 100_000;
  // Time base rate, in Hz
  localparam int unsigned TIMEBASE_HZ = 32_768;
  localparam int unsigned TB_DIV_W = 16;
  // Reset values, last conversion count and full queue level
  localparam logic [DELAY_W-1:0] START_DELAY_RST = 8'h00;
  localparam logic [CHAN_W-1:0] INDEX_RST = 3'h0;
  localparam logic [RESULT_W-1:0] RESULT_RST = 10'h000;
  localparam logic [CHAN_W-1:0] LAST_CONV = 3'h7;
  localparam logic [1:0] PEND_FULL = 2'h2;
  // First channel with a direct general-purpose input
  localparam logic [CHAN_W-1:0] DIRECT_CHAN_FIRST = 3'h5;

  // Time base divide ratio for a given PLL setting, never below one
  function automatic int unsigned tb_div(input int unsigned setting);
    int unsigned core_hz;
    int unsigned div;
    core_hz = ((PLL_BASE_HZ + setting * PLL_STEP_HZ) / CORE_DEN) * CORE_NUM;
    div = core_hz / TIMEBASE_HZ;
    return (div < 1) ? 1 : div;
  endfunction

  typedef enum logic [2:0] {
    ADCSQ_IDLE,
    ADCSQ_SYNC,
    ADCSQ_DELAY,
    ADCSQ_CONV,
    ADCSQ_WAIT
  } adcsq_state_e;
endpackage

/* File: logic/adcsq_control.sv */
// Converter sequencer: request queue, settings, results on ref clock; sequencing on core clock
`timescale 1ns/1ps
// What this block does
// - Results are 10 bits; sequencing runs on the 2/3 PLL core clock.
// - A pending request asks the switcher PLL on before converting.
// - 32.768 kHz time base divider follows PLL setting so its rate stays constant.
// - Three-bit code 000 to 111 selects channel 0 to 7.
// - Remap bit set raises touch select for the whole series, on every channel.
// - Input buffer on for direct inputs only during an active conversion.
// - Up to two requests queue and run one after another.
// - Series end sets done flag; mask suppresses the interrupt signal.
// - Trigger pin rising edge or software start write begins a series.
// - Start flag reads high during any series and clears at completion.
// - Eight conversions: each channel once, or index A channel eight times.
// - Calibration series clears calibration request and raises done at end.
// - Start after sync plus 1 to 256 time base periods, field plus one.
// - Delay bit inserts the start delay between successive conversions.
// - Eight slots; read gives two values by two indices; calibration not stored.
// - Auto-increment bits advance index fields after each result read.
// - Core reset aborts converter state but keeps settings and stored results.
module adcsq_control (
  // Reference clock domain
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Converter core clock, two thirds of the switcher PLL
  input wire logic core_clk_in,
  // Start sources
  input wire logic external_trigger_pin_in,
  input wire logic start_write_in,
  output logic conversion_start_flag_out,
  // Settings
  input wire logic single_channel_select_in,
  input wire logic [adcsq_pkg::DELAY_W-1:0] start_delay_count_in,
  input wire logic delay_between_conversions_in,
  input wire logic touch_input_remap_in,
  input wire logic input_buffer_enable_in,
  input wire logic [adcsq_pkg::PLL_SET_W-1:0] switcher_pll_setting_in,
  input wire logic converter_core_reset_in,
  // Calibration request bit
  input wire logic calibration_set_in,
  output logic calibration_request_out,
  // Done interrupt
  input wire logic conversion_done_mask_in,
  input wire logic done_clear_in,
  output logic conversion_done_irq_out,
  output logic conversion_done_int_out,
  // Result readout
  input wire logic index_a_write_in,
  input wire logic index_b_write_in,
  input wire logic [adcsq_pkg::CHAN_W-1:0] index_data_in,
  input wire logic index_a_autoinc_in,
  input wire logic index_b_autoinc_in,
  input wire logic result_read_in,
  output logic [adcsq_pkg::CHAN_W-1:0] result_index_a_out,
  output logic [adcsq_pkg::CHAN_W-1:0] result_index_b_out,
  output logic [adcsq_pkg::RESULT_W-1:0] result_value_a_out,
  output logic [adcsq_pkg::RESULT_W-1:0] result_value_b_out,
  // Switcher PLL
  input wire logic pll_active_in,
  output logic pll_enable_out,
  // Analog core, core clock domain
  input wire logic adc_ready_in,
  input wire logic [adcsq_pkg::RESULT_W-1:0] adc_data_in,
  output logic adc_start_out,
  output logic [adcsq_pkg::CHAN_W-1:0] adc_channel_out,
  output logic adc_calibrate_out,
  output logic adc_touch_select_out,
  output logic input_buffer_on_out
);
  localparam int unsigned RW = adcsq_pkg::RESULT_W;
  localparam int unsigned CW = adcsq_pkg::CHAN_W;
  localparam int unsigned DW = adcsq_pkg::DELAY_W;

  // ---------------- Reference domain ----------------
  logic trig_s1, trig_s2, trig_s3;
  logic done_s1, done_s2, done_s3;
  logic pll_s1, pll_s2;
  logic busy, next_busy;
  logic [1:0] pend, next_pend;
  logic start_tgl, next_start_tgl;
  logic reset_tgl, next_reset_tgl;
  logic job_single, job_cal, job_gap, job_remap, job_buf;
  logic next_job_single, next_job_cal, next_job_gap, next_job_remap, next_job_buf;
  logic [CW-1:0] job_chan, next_job_chan;
  logic [DW-1:0] job_delay, next_job_delay;
  logic [adcsq_pkg::PLL_SET_W-1:0] job_pll, next_job_pll;
  logic cal_req, next_cal_req;
  logic done_flag, next_done_flag;
  logic [CW-1:0] idx_a, next_idx_a, idx_b, next_idx_b;
  logic [RW-1:0] val_a, next_val_a, val_b, next_val_b;
  logic [RW-1:0] slot [adcsq_pkg::SLOTS];
  logic [RW-1:0] next_slot [adcsq_pkg::SLOTS];
  logic [RW-1:0] stage [adcsq_pkg::SLOTS];
  logic trig_rise, req, done_evt, launch;
  // Written on the core clock, only read here through done_s1
  logic done_tgl, next_done_tgl;

  // Pin and return toggle pass two flops before use
  always_ff @(posedge ref_clk_in) begin
    trig_s1 <= external_trigger_pin_in;
    trig_s2 <= trig_s1;
    trig_s3 <= trig_s2;
    done_s1 <= done_tgl;
    done_s2 <= done_s1;
    done_s3 <= done_s2;
    pll_s1 <= pll_active_in;
    pll_s2 <= pll_s1;
  end

  assign trig_rise = trig_s2 & ~trig_s3 & ~rst_in;
  assign req = trig_rise | start_write_in;
  // Stray toggles outside a series are ignored
  assign done_evt = busy & (done_s2 ^ done_s3);
  // Launch only once the previous series has signalled done and the PLL runs
  assign launch = ~busy & (pend != 2'h0) & ~converter_core_reset_in & pll_s2;

  always_comb begin
    next_busy = busy;
    next_pend = pend;
    next_start_tgl = start_tgl;
    next_reset_tgl = reset_tgl;
    next_job_single = job_single;
    next_job_cal = job_cal;
    next_job_gap = job_gap;
    next_job_remap = job_remap;
    next_job_buf = job_buf;
    next_job_chan = job_chan;
    next_job_delay = job_delay;
    next_job_pll = job_pll;
    next_cal_req = cal_req;
    next_done_flag = done_flag;
    next_idx_a = idx_a;
    next_idx_b = idx_b;
    next_val_a = val_a;
    next_val_b = val_b;
    for (int i = 0; i < adcsq_pkg::SLOTS; i++) begin
      next_slot[i] = (done_evt & ~job_cal) ? stage[i] : slot[i];
    end
    if (launch) begin
      next_pend = pend - 2'h1;
      next_busy = 1'b1;
      next_start_tgl = ~start_tgl;
      next_job_single = single_channel_select_in;
      next_job_cal = cal_req;
      next_job_gap = delay_between_conversions_in;
      next_job_remap = touch_input_remap_in;
      next_job_buf = input_buffer_enable_in;
      next_job_chan = idx_a;
      next_job_delay = start_delay_count_in;
      next_job_pll = switcher_pll_setting_in;
    end
    if (req && (next_pend != adcsq_pkg::PEND_FULL)) begin
      next_pend = next_pend + 2'h1;
    end
    if (done_evt) begin
      next_busy = 1'b0;
      if (job_cal) begin
        next_cal_req = 1'b0;
      end
    end
    // Core reset drops the series and queue, stored results stay
    if (converter_core_reset_in) begin
      next_busy = 1'b0;
      next_pend = 2'h0;
      next_reset_tgl = ~reset_tgl;
    end
    // Set wins over the clears
    if (calibration_set_in) begin
      next_cal_req = 1'b1;
    end
    if (done_clear_in) begin
      next_done_flag = 1'b0;
    end
    if (done_evt) begin
      next_done_flag = 1'b1;
    end
    if (result_read_in) begin
      next_val_a = slot[idx_a];
      next_val_b = slot[idx_b];
      if (index_a_autoinc_in) begin
        next_idx_a = idx_a + 3'h1;
      end
      if (index_b_autoinc_in) begin
        next_idx_b = idx_b + 3'h1;
      end
    end
    if (index_a_write_in) begin
      next_idx_a = index_data_in;
    end
    if (index_b_write_in) begin
      next_idx_b = index_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      pend <= 2'h0;
      start_tgl <= 1'b0;
      reset_tgl <= 1'b0;
      job_single <= 1'b0;
      job_cal <= 1'b0;
      job_gap <= 1'b0;
      job_remap <= 1'b0;
      job_buf <= 1'b0;
      job_chan <= adcsq_pkg::INDEX_RST;
      job_delay <= adcsq_pkg::START_DELAY_RST;
      job_pll <= '0;
      cal_req <= 1'b0;
      done_flag <= 1'b0;
      idx_a <= adcsq_pkg::INDEX_RST;
      idx_b <= adcsq_pkg::INDEX_RST;
      val_a <= adcsq_pkg::RESULT_RST;
      val_b <= adcsq_pkg::RESULT_RST;
      for (int i = 0; i < adcsq_pkg::SLOTS; i++) begin
        slot[i] <= adcsq_pkg::RESULT_RST;
      end
    end else begin
      busy <= next_busy;
      pend <= next_pend;
      start_tgl <= next_start_tgl;
      reset_tgl <= next_reset_tgl;
      job_single <= next_job_single;
      job_cal <= next_job_cal;
      job_gap <= next_job_gap;
      job_remap <= next_job_remap;
      job_buf <= next_job_buf;
      job_chan <= next_job_chan;
      job_delay <= next_job_delay;
      job_pll <= next_job_pll;
      cal_req <= next_cal_req;
      done_flag <= next_done_flag;
      idx_a <= next_idx_a;
      idx_b <= next_idx_b;
      val_a <= next_val_a;
      val_b <= next_val_b;
      for (int i = 0; i < adcsq_pkg::SLOTS; i++) begin
        slot[i] <= next_slot[i];
      end
    end
  end

  assign conversion_start_flag_out = busy;
  assign calibration_request_out = cal_req;
  assign conversion_done_irq_out = done_flag;
  assign conversion_done_int_out = done_flag & ~conversion_done_mask_in;
  assign result_index_a_out = idx_a;
  assign result_index_b_out = idx_b;
  assign result_value_a_out = val_a;
  assign result_value_b_out = val_b;
  // Core clock only runs with the PLL on, so hold it on while work waits
  assign pll_enable_out = rst_in | busy | (pend != 2'h0);

  // ---------------- Core clock domain ----------------
  logic crst_s1, crst_s2;
  logic st_s1, st_s2, st_s3;
  logic rs_s1, rs_s2, rs_s3;
  adcsq_pkg::adcsq_state_e state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [DW:0] dly, next_dly;
  logic [adcsq_pkg::TB_DIV_W-1:0] tb_cnt, next_tb_cnt;
  logic [adcsq_pkg::TB_DIV_W-1:0] div_tab [2**adcsq_pkg::PLL_SET_W];
  logic [RW-1:0] next_stage [adcsq_pkg::SLOTS];
  logic tick, start_evt, abort_evt, core_rst;
  logic [CW-1:0] chan;

  always_ff @(posedge core_clk_in) begin
    crst_s1 <= rst_in;
    crst_s2 <= crst_s1;
    st_s1 <= start_tgl;
    st_s2 <= st_s1;
    st_s3 <= st_s2;
    rs_s1 <= reset_tgl;
    rs_s2 <= rs_s1;
    rs_s3 <= rs_s2;
  end

  // Divide ratio per PLL setting keeps the time base rate fixed
  for (genvar g = 0; g < 2**adcsq_pkg::PLL_SET_W; g++) begin : g_div
    assign div_tab[g] = adcsq_pkg::TB_DIV_W'(adcsq_pkg::tb_div(g) - 1);
  end

  assign core_rst = crst_s2;
  assign start_evt = st_s2 ^ st_s3;
  assign abort_evt = rs_s2 ^ rs_s3;
  assign tick = (tb_cnt == div_tab[job_pll]);
  // Next count, so the channel stands with the start pulse it belongs to
  assign chan = job_single ? job_chan : next_cnt;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_dly = dly;
    next_done_tgl = done_tgl;
    next_tb_cnt = tick ? '0 : tb_cnt + 16'h0001;
    for (int i = 0; i < adcsq_pkg::SLOTS; i++) begin
      next_stage[i] = stage[i];
    end
    case (state)
      adcsq_pkg::ADCSQ_IDLE: begin
        next_cnt = '0;
      end
      adcsq_pkg::ADCSQ_SYNC: begin
        if (tick) begin
          next_dly = {1'b0, job_delay};
          next_state = adcsq_pkg::ADCSQ_DELAY;
        end
      end
      adcsq_pkg::ADCSQ_DELAY: begin
        if (tick) begin
          if (dly == '0) begin
            next_state = adcsq_pkg::ADCSQ_CONV;
          end else begin
            next_dly = dly - 9'h001;
          end
        end
      end
      adcsq_pkg::ADCSQ_CONV: begin
        next_state = adcsq_pkg::ADCSQ_WAIT;
      end
      adcsq_pkg::ADCSQ_WAIT: begin
        if (adc_ready_in) begin
          next_stage[cnt] = adc_data_in;
          if (cnt == adcsq_pkg::LAST_CONV) begin
            next_done_tgl = ~done_tgl;
            next_state = adcsq_pkg::ADCSQ_IDLE;
          end else begin
            next_cnt = cnt + 3'h1;
            next_dly = {1'b0, job_delay};
            next_state = job_gap ? adcsq_pkg::ADCSQ_DELAY : adcsq_pkg::ADCSQ_CONV;
          end
        end
      end
      default: begin
        next_state = adcsq_pkg::ADCSQ_IDLE;
      end
    endcase
    if (abort_evt) begin
      next_state = adcsq_pkg::ADCSQ_IDLE;
      for (int i = 0; i < adcsq_pkg::SLOTS; i++) begin
        next_stage[i] = adcsq_pkg::RESULT_RST;
      end
    end
    if (start_evt) begin
      next_cnt = '0;
      next_state = adcsq_pkg::ADCSQ_SYNC;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (core_rst) begin
      state <= adcsq_pkg::ADCSQ_IDLE;
      cnt <= '0;
      dly <= '0;
      done_tgl <= 1'b0;
      tb_cnt <= '0;
      adc_start_out <= 1'b0;
      adc_channel_out <= '0;
      adc_calibrate_out <= 1'b0;
      adc_touch_select_out <= 1'b0;
      input_buffer_on_out <= 1'b0;
      for (int i = 0; i < adcsq_pkg::SLOTS; i++) begin
        stage[i] <= adcsq_pkg::RESULT_RST;
      end
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      dly <= next_dly;
      done_tgl <= next_done_tgl;
      tb_cnt <= next_tb_cnt;
      adc_start_out <= (next_state == adcsq_pkg::ADCSQ_CONV);
      adc_channel_out <= (next_state == adcsq_pkg::ADCSQ_IDLE) ? '0 : chan;
      adc_calibrate_out <= job_cal & (next_state != adcsq_pkg::ADCSQ_IDLE);
      adc_touch_select_out <= job_remap & (next_state != adcsq_pkg::ADCSQ_IDLE);
      input_buffer_on_out <= job_buf & (chan >= adcsq_pkg::DIRECT_CHAN_FIRST)
        & ((next_state == adcsq_pkg::ADCSQ_CONV) | (next_state == adcsq_pkg::ADCSQ_WAIT));
      for (int i = 0; i < adcsq_pkg::SLOTS; i++) begin
        stage[i] <= next_stage[i];
      end
    end
  end
endmodule  // adcsq_control

/* File: tb/adcsq_control_properties.sv */
// Port-level checks of the converter sequencer, bound to its top module
`timescale 1ns/1ps
module adcsq_control_chk (
  // Clocks and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic core_clk_in,
  // Watched ports
  input wire logic conversion_start_flag_out,
  input wire logic converter_core_reset_in,
  input wire logic pll_active_in,
  input wire logic conversion_done_mask_in,
  input wire logic conversion_done_irq_out,
  input wire logic conversion_done_int_out,
  input wire logic index_a_write_in,
  input wire logic index_b_write_in,
  input wire logic index_a_autoinc_in,
  input wire logic index_b_autoinc_in,
  input wire logic result_read_in,
  input wire logic [adcsq_pkg::CHAN_W-1:0] result_index_a_out,
  input wire logic [adcsq_pkg::CHAN_W-1:0] result_index_b_out,
  input wire logic pll_enable_out,
  input wire logic adc_start_out,
  input wire logic [adcsq_pkg::CHAN_W-1:0] adc_channel_out,
  input wire logic input_buffer_on_out
);
  property p_int_mask;
    @(posedge ref_clk_in) disable iff (rst_in)
    conversion_done_int_out == (conversion_done_irq_out && !conversion_done_mask_in);
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("done signal ignores mask");
  property p_flag_fall;
    @(posedge ref_clk_in) disable iff (rst_in)
    $fell(conversion_start_flag_out) && !$past(converter_core_reset_in)
      |-> conversion_done_irq_out;
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("busy ended without done");
  property p_irq_rise;
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(conversion_done_irq_out) |-> $fell(conversion_start_flag_out);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("done set while series runs");
  property p_pll;
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(conversion_start_flag_out) |-> $past(pll_active_in, 2) && pll_enable_out;
  endproperty
  a_pll: assert property (p_pll) else $error("series runs with pll off");
  property p_inc_a;
    @(posedge ref_clk_in) disable iff (rst_in)
    result_read_in && index_a_autoinc_in && !index_a_write_in
      |=> result_index_a_out == $past(result_index_a_out) + 3'h1;
  endproperty
  a_inc_a: assert property (p_inc_a) else $error("index a did not advance");
  property p_inc_b;
    @(posedge ref_clk_in) disable iff (rst_in)
    result_read_in && !index_b_autoinc_in && !index_b_write_in |=> $stable(result_index_b_out);
  endproperty
  a_inc_b: assert property (p_inc_b) else $error("index b moved");
  property p_start_pulse;
    @(posedge core_clk_in) disable iff (rst_in)
    adc_start_out |=> !adc_start_out;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_buffer;
    @(posedge core_clk_in) disable iff (rst_in)
    $rose(input_buffer_on_out) |-> adc_channel_out >= adcsq_pkg::DIRECT_CHAN_FIRST;
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer on for channel");
endmodule // adcsq_control_chk

bind adcsq_control adcsq_control_chk u_chk (.ref_clk_in, .rst_in, .core_clk_in,
  .conversion_start_flag_out, .converter_core_reset_in, .pll_active_in,
  .conversion_done_mask_in, .conversion_done_irq_out,
  .conversion_done_int_out, .index_a_write_in, .index_b_write_in, .index_a_autoinc_in,
  .index_b_autoinc_in, .result_read_in, .result_index_a_out, .result_index_b_out,
  .pll_enable_out, .adc_start_out, .adc_channel_out, .input_buffer_on_out);

/* File: tb/adcsq_core_model.sv */
// Behavioural analog converter core answering start pulses
`timescale 1ns/1ps
module adcsq_core_model (
  // Clock, reset and answer speed
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  // Converter handshake
  input wire logic start_in,
  input wire logic [2:0] channel_in,
  output logic ready_out,
  output logic [9:0] data_out
);
  logic [2:0] conv_k;
  logic [2:0] wait_n;
  logic busy;
  logic [9:0] last;
  // Data only valid with ready; otherwise show the inverse so stale reads fail
  assign data_out = ready_out ? last : ~last;
  always @(posedge core_clk_in) begin
    ready_out <= 1'b0;
    if (rst_in) begin
      conv_k <= 3'h0;
      busy <= 1'b0;
      last <= 10'h000;
    end else if (start_in) begin
      busy <= 1'b1;
      wait_n <= slow_in ? 3'h5 : 3'h0;
      last <= {3'h5, conv_k, 1'b0, channel_in};
    end else if (busy) begin
      if (wait_n == 3'h0) begin
        busy <= 1'b0;
        ready_out <= 1'b1;
        conv_k <= conv_k + 3'h1;
      end else begin
        wait_n <= wait_n - 3'h1;
      end
    end
  end
endmodule // adcsq_core_model

/* File: tb/testbench.sv */
// Self-checking bench for the converter sequencer control
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in, rst_in, core_clk_in, external_trigger_pin_in, start_write_in, slow;
  logic conversion_start_flag_out, single_channel_select_in, delay_between_conversions_in;
  logic touch_input_remap_in, input_buffer_enable_in, converter_core_reset_in, pll_active_in;
  logic calibration_set_in, calibration_request_out, conversion_done_mask_in, done_clear_in;
  logic conversion_done_irq_out, conversion_done_int_out, index_a_write_in, index_b_write_in;
  logic index_a_autoinc_in, index_b_autoinc_in, result_read_in, pll_enable_out, adc_ready_in;
  logic adc_start_out, adc_calibrate_out, adc_touch_select_out, input_buffer_on_out;
  logic [7:0] start_delay_count_in;
  logic [2:0] switcher_pll_setting_in, index_data_in, result_index_a_out, result_index_b_out;
  logic [2:0] adc_channel_out;
  logic [9:0] result_value_a_out, result_value_b_out, adc_data_in;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  adcsq_control dut (.ref_clk_in, .rst_in, .core_clk_in, .external_trigger_pin_in,
    .start_write_in, .conversion_start_flag_out, .single_channel_select_in,
    .start_delay_count_in, .delay_between_conversions_in, .touch_input_remap_in,
    .input_buffer_enable_in, .switcher_pll_setting_in, .converter_core_reset_in,
    .calibration_set_in, .calibration_request_out, .conversion_done_mask_in, .done_clear_in,
    .conversion_done_irq_out, .conversion_done_int_out, .index_a_write_in, .index_b_write_in,
    .index_data_in, .index_a_autoinc_in, .index_b_autoinc_in, .result_read_in,
    .result_index_a_out, .result_index_b_out, .result_value_a_out, .result_value_b_out,
    .pll_active_in, .pll_enable_out, .adc_ready_in, .adc_data_in, .adc_start_out,
    .adc_channel_out, .adc_calibrate_out, .adc_touch_select_out, .input_buffer_on_out);
  adcsq_core_model core (.core_clk_in, .rst_in, .slow_in(slow), .start_in(adc_start_out),
    .channel_in(adc_channel_out), .ready_out(adc_ready_in), .data_out(adc_data_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    core_clk_in = 1'b0;
    #13;
    forever #32 core_clk_in = ~core_clk_in;
  end
  function automatic logic [9:0] cv(input logic [2:0] k, input logic [2:0] ch);
    return {3'h5, k, 1'b0, ch};
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bits: core reset, done clear, calibration set, start write
  task automatic cmd(input logic [3:0] m);
    @(posedge ref_clk_in);
    {converter_core_reset_in, done_clear_in, calibration_set_in, start_write_in} <= m;
    @(posedge ref_clk_in);
    {converter_core_reset_in, done_clear_in, calibration_set_in, start_write_in} <= 4'h0;
    #1;
  endtask
  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (conversion_start_flag_out !== v && n < 5000) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    if (n == 5000) err_total++;
  endtask
  task automatic set_idx(input logic [2:0] a, input logic [2:0] b);
    @(posedge ref_clk_in);
    index_a_write_in <= 1'b1;
    index_data_in <= a;
    @(posedge ref_clk_in);
    index_a_write_in <= 1'b0;
    index_b_write_in <= 1'b1;
    index_data_in <= b;
    @(posedge ref_clk_in);
    index_b_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] ea, input logic [9:0] eb);
    @(posedge ref_clk_in);
    result_read_in <= 1'b1;
    @(posedge ref_clk_in);
    result_read_in <= 1'b0;
    #1;
    check(result_value_a_out, ea);
    check(result_value_b_out, eb);
  endtask
  task automatic series();
    wait_flag(1'b1);
    wait_flag(1'b0);
  endtask
  // Switcher PLL reports running one cycle after it is asked
  always @(posedge ref_clk_in) begin
    pll_active_in <= pll_enable_out;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    rst_in = 1'b1;
    {external_trigger_pin_in, start_write_in, single_channel_select_in, slow} = 4'h0;
    {delay_between_conversions_in, touch_input_remap_in, converter_core_reset_in} = 3'h0;
    {calibration_set_in, conversion_done_mask_in, done_clear_in, result_read_in} = 4'h0;
    {index_a_write_in, index_b_write_in, index_a_autoinc_in, index_b_autoinc_in} = 4'h0;
    {switcher_pll_setting_in, index_data_in} = 6'h00;
    start_delay_count_in = 8'h00;
    input_buffer_enable_in = 1'b1;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    // Software start, one conversion per channel
    set_idx(3'h0, 3'h4);
    index_a_autoinc_in <= 1'b1;
    index_b_autoinc_in <= 1'b1;
    cmd(4'h1);
    wait_flag(1'b1);
    check(10'(pll_enable_out), 10'h001);
    wait_flag(1'b0);
    check(10'(conversion_done_int_out), 10'h001);
    for (int i = 0; i < 8; i++) rd(cv(3'(i), 3'(i)), cv(3'(i + 4), 3'(i + 4)));
    check(10'(result_index_a_out), 10'h000);
    // Trigger pin start, single channel, gap delays, slow core
    @(posedge ref_clk_in);
    {single_channel_select_in, touch_input_remap_in, delay_between_conversions_in} <= 3'h7;
    {index_b_autoinc_in, slow} <= 2'h1;
    start_delay_count_in <= 8'h01;
    set_idx(3'h6, 3'h4);
    external_trigger_pin_in <= 1'b1;
    wait_flag(1'b1);
    @(posedge adc_start_out);
    #1;
    check(10'(adc_channel_out), 10'h006);
    check(10'(adc_touch_select_out), 10'h001);
    wait_flag(1'b0);
    @(posedge ref_clk_in);
    external_trigger_pin_in <= 1'b0;
    set_idx(3'h0, 3'h4);
    for (int i = 0; i < 8; i++) rd(cv(3'(i), 3'h6), cv(3'h4, 3'h6));
    check(10'(result_index_b_out), 10'h004);
    // Queue: three accepted, fourth dropped, interrupt masked
    cmd(4'h4);
    check(10'(conversion_done_irq_out), 10'h000);
    @(posedge ref_clk_in);
    {single_channel_select_in, touch_input_remap_in, delay_between_conversions_in} <= 3'h0;
    {conversion_done_mask_in, slow} <= 2'h2;
    repeat (4) cmd(4'h1);
    repeat (3) series();
    check(10'(conversion_done_int_out), 10'h000);
    repeat (300) @(posedge ref_clk_in);
    #1;
    check(10'(conversion_start_flag_out), 10'h000);
    // Calibration series leaves stored results alone
    @(posedge ref_clk_in);
    conversion_done_mask_in <= 1'b0;
    // Single channel 0, so stored calibration results would show in slot 4
    single_channel_select_in <= 1'b1;
    cmd(4'h6);
    check(10'(calibration_request_out), 10'h001);
    check(10'(conversion_done_irq_out), 10'h000);
    cmd(4'h1);
    @(posedge adc_start_out);
    #1;
    check(10'(adc_calibrate_out), 10'h001);
    series();
    check(10'(calibration_request_out), 10'h000);
    check(10'(conversion_done_irq_out), 10'h001);
    rd(cv(3'h0, 3'h0), cv(3'h4, 3'h4));
    // Core reset aborts a running series, results kept
    cmd(4'h1);
    wait_flag(1'b1);
    @(posedge adc_start_out);
    cmd(4'h8);
    check(10'(conversion_start_flag_out), 10'h000);
    rd(cv(3'h1, 3'h1), cv(3'h4, 3'h4));
    // Single channel select is cleared again before the bench stops
    @(posedge ref_clk_in);
    single_channel_select_in <= 1'b0;
    stop_test();
  end
endmodule // testbench
